// File: hdl/sar_pkg.sv
// package for the serial receiver: frame field widths, sample points, encodings
// assumes a single 100 MHz system clock and a baud-rate divider elsewhere
package sar_pkg;

    // ------------------------------------------------------------------
    // oversampling
    // ------------------------------------------------------------------
    localparam int unsigned SAMPLES_NORMAL = 16;
    localparam int unsigned SAMPLES_DOUBLE = 8;
    localparam logic [3:0]  VOTE_FIRST_NORMAL = 4'h8; // first centre sample, normal
    localparam logic [3:0]  VOTE_FIRST_DOUBLE = 4'h4; // first centre sample, double speed
    localparam logic [3:0]  LAST_NORMAL = 4'hf;
    localparam logic [3:0]  LAST_DOUBLE = 4'h7;

    // ------------------------------------------------------------------
    // frame format
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned BUF_DEPTH  = 2;
    localparam logic [2:0]  SIZE_9BIT  = 3'h7; // char_size_field code for nine bits
    localparam logic [2:0]  SIZE_5BIT  = 3'h0;
    localparam int unsigned BAUD_DIV_W = 12;
    localparam logic [11:0] BAUD_DIV_RESET = 12'h000;

    // buffered entry: {frame_err, parity_err, ninth, data}
    localparam int unsigned ENTRY_W    = DATA_W + 3;
    localparam int unsigned POS_NINTH  = DATA_W;
    localparam int unsigned POS_PERR   = DATA_W + 1;
    localparam int unsigned POS_FERR   = DATA_W + 2;

    typedef enum logic [1:0] {
        SAR_IDLE,
        SAR_START,
        SAR_BITS
    } sar_state_e;

endpackage

// File: hdl/sar_rate.sv
// sample-rate divider: one-cycle enable at 16x or 8x baud
// assumes the divisor input is held steady while the receiver runs
module sar_rate (
    // clock and reset
    input  wire logic                           I_CLOCK,
    input  wire logic                           I_RESETN,
    // control
    input  wire logic                           i_run,
    input  wire logic [sar_pkg::BAUD_DIV_W-1:0] i_div,
    // sample enable
    output logic                                o_tick
);
    import sar_pkg::*;

    logic [BAUD_DIV_W-1:0] cnt_r;
    wire                   at_end = (cnt_r >= i_div);

    // --------------------------------------------------------------
    // count up to the divisor, pulse at wrap
    // --------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cnt_r  <= '0;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt_r  <= '0;
            o_tick <= 1'b0;
        end else begin
            cnt_r  <= at_end ? '0 : cnt_r + 1'b1;
            o_tick <= at_end;
        end
    end
endmodule

// File: hdl/sar_rxbuf.sv
// two-entry receive buffer holding data, ninth bit and error status
// assumes the writer never pushes when full
module sar_rxbuf #(
    parameter int unsigned WIDTH = sar_pkg::ENTRY_W
) (
    // clock and reset
    input  wire logic             I_CLOCK,
    input  wire logic             I_RESETN,
    // control
    input  wire logic             i_flush,
    input  wire logic             i_push,
    input  wire logic [WIDTH-1:0] i_entry,
    input  wire logic             i_pop,
    // state
    output logic      [WIDTH-1:0] o_head,
    output logic                  o_empty,
    output logic                  o_full
);
    import sar_pkg::*;

    logic [WIDTH-1:0] mem_r [BUF_DEPTH];
    logic             rd_r;
    logic             wr_r;
    logic [1:0]       cnt_r;

    wire do_pop  = i_pop & (cnt_r != 2'h0);
    wire do_push = i_push & (cnt_r != 2'h2);

    assign o_head  = mem_r[rd_r];
    assign o_empty = (cnt_r == 2'h0);
    assign o_full  = (cnt_r == 2'h2);

    // --------------------------------------------------------------
    // pointers and occupancy; flush empties the buffer
    // --------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else if (i_flush) begin
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (do_pop) begin
                rd_r <= ~rd_r;
            end
            if (do_push) begin
                wr_r <= ~wr_r;
            end
            cnt_r <= cnt_r + {1'b0, do_push} - {1'b0, do_pop};
        end
    end

    // storage
    always_ff @(posedge I_CLOCK) begin
        if (do_push && !i_flush) begin
            mem_r[wr_r] <= i_entry;
        end
    end
endmodule

// File: hdl/sar_receiver.sv
// asynchronous serial receiver: start detect, majority recovery, two-entry buffer
// assumes i_rxd is synchronous to I_CLOCK and control inputs come from software
//
// Notes on behaviour
// - ninth bit and errors buffered; data read advances
// - complete flag high while buffer non-empty
// - receiver disable flushes buffer
// - interrupt requested while enabled and flag set
// - framing and parity error flags follow buffered head character
// - error flags not writable by software
// - error flags raise no interrupt
// - framing error from first stop bit only
// - overrun when buffer full, shifter waiting, start
// - overrun clears on successful transfer to buffer
// - parity checked per enable and odd select
// - parity error zero when checking disabled
// - parity error valid until data read
// - disable immediate, frame dropped, pin released
// - sample at 16x, or 8x double speed
// - samples 8,9,10 or 4,5,6 vote start
// - high majority rejects start, else synchronise
// - shift bits until first stop, then transfer
// - each bit decided by three-sample majority
// - unused upper data bits read zero
module sar_receiver (
    // clock and reset
    input  wire logic                           I_CLOCK,
    input  wire logic                           I_RESETN,
    // serial line
    input  wire logic                           I_RXD,
    // configuration
    input  wire logic                           I_RECEIVER_ENABLE_BIT,
    input  wire logic                           I_RX_COMPLETE_IRQ_ENABLE,
    input  wire logic                           I_PARITY_ENABLE_BIT,
    input  wire logic                           I_PARITY_ODD_SELECT,
    input  wire logic                           I_STOP_BITS_SELECT,
    input  wire logic                           I_DOUBLE_SPEED_BIT,
    input  wire logic [2:0]                     I_CHAR_SIZE_FIELD,
    input  wire logic [sar_pkg::BAUD_DIV_W-1:0] I_BAUD_DIV,
    // data register read strobe
    input  wire logic                           I_RX_DATA_READ,
    // receive data register and status
    output logic      [sar_pkg::DATA_W-1:0]     O_RX_DATA_REG,
    output logic                                O_RX_NINTH_BIT,
    output logic                                O_FRAMING_ERROR_FLAG,
    output logic                                O_OVERRUN_FLAG,
    output logic                                O_PARITY_ERROR_FLAG,
    output logic                                O_RX_COMPLETE_FLAG,
    output logic                                O_RX_COMPLETE_IRQ,
    output logic                                O_PIN_OVERRIDE
);
    import sar_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic vote3(input logic [2:0] s);
        vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    // number of data bits for a char_size_field code
    function automatic logic [3:0] data_bits(input logic [2:0] code);
        if (code == SIZE_9BIT) begin
            data_bits = 4'h9;
        end else if (code > 3'h3) begin
            data_bits = 4'h8;
        end else begin
            data_bits = 4'h5 + {2'h0, code[1:0]};
        end
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    sar_state_e          state_r;
    logic [3:0]          samp_r;       // sample number within a bit
    logic [3:0]          bitn_r;       // bits received after start
    logic [2:0]          win_r;        // centre samples
    logic                prev_rxd_r;
    logic [8:0]          shift_r;      // data bits, lsb first
    logic                par_bit_r;
    logic                hold_r;       // completed frame waits in shifter
    logic [ENTRY_W-1:0]  hold_entry_r;
    logic                dor_r;        // pending overrun, cleared by next push
    logic                tick;
    logic [ENTRY_W-1:0]  head;
    logic                buf_empty;
    logic                buf_full;

    wire       en      = I_RECEIVER_ENABLE_BIT;
    wire [3:0] vfirst  = I_DOUBLE_SPEED_BIT ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
    wire [3:0] vlast   = I_DOUBLE_SPEED_BIT ? LAST_DOUBLE : LAST_NORMAL;
    wire [3:0] ndata   = data_bits(I_CHAR_SIZE_FIELD);
    wire [3:0] nframe  = ndata + {3'h0, I_PARITY_ENABLE_BIT}; // bits before the stop bit
    wire       in_win  = (samp_r >= vfirst) && (samp_r <= vfirst + 4'h2);
    wire       dec_pt  = tick && (samp_r == vfirst + 4'h2);
    wire [2:0] win_nxt = {I_RXD, win_r[2:1]};
    wire       bit_val = vote3(win_nxt);
    wire       falling = prev_rxd_r && !I_RXD;

    // parity computed over the data bits actually used
    wire [8:0] dmask   = 9'h1ff >> (4'h9 - ndata);
    wire       dpar    = ^(shift_r & dmask);
    wire       perr    = I_PARITY_ENABLE_BIT &&
                         ((dpar ^ I_PARITY_ODD_SELECT) != par_bit_r);

    wire       stop_pt = dec_pt && (state_r == SAR_BITS) && (bitn_r == nframe);
    wire       start_ok = dec_pt && (state_r == SAR_START) && !bit_val;
    wire       push    = en && hold_r && !buf_full;
    wire       pop     = I_RX_DATA_READ && !buf_empty;

    // ------------------------------------------------------------------
    // sample-rate divider and buffer
    // ------------------------------------------------------------------
    sar_rate u_rate (
        .I_CLOCK  (I_CLOCK),
        .I_RESETN (I_RESETN),
        .i_run    (en),
        .i_div    (I_BAUD_DIV),
        .o_tick   (tick)
    );

    sar_rxbuf #(
        .WIDTH (ENTRY_W)
    ) u_buf (
        .I_CLOCK  (I_CLOCK),
        .I_RESETN (I_RESETN),
        .i_flush  (!en),
        .i_push   (push),
        .i_entry  (hold_entry_r),
        .i_pop    (pop),
        .o_head   (head),
        .o_empty  (buf_empty),
        .o_full   (buf_full)
    );

    // ------------------------------------------------------------------
    // clock and data recovery
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_r    <= SAR_IDLE;
            samp_r     <= 4'h0;
            bitn_r     <= 4'h0;
            win_r      <= 3'h7;
            prev_rxd_r <= 1'b1;
            shift_r    <= 9'h000;
            par_bit_r  <= 1'b0;
        end else if (!en) begin
            state_r    <= SAR_IDLE;
            samp_r     <= 4'h0;
            bitn_r     <= 4'h0;
            prev_rxd_r <= 1'b1;
        end else if (tick) begin
            prev_rxd_r <= I_RXD;
            samp_r     <= (samp_r == vlast) ? 4'h0 : samp_r + 4'h1;
            if (in_win) begin
                win_r <= win_nxt;
            end
            case (state_r)
                SAR_IDLE: begin
                    if (falling) begin
                        state_r <= SAR_START;
                        samp_r  <= 4'h2;  // this low sample is number 1
                    end
                end
                SAR_START: begin
                    if (dec_pt) begin
                        if (bit_val) begin
                            state_r <= SAR_IDLE;
                        end else begin
                            state_r <= SAR_BITS;
                            bitn_r  <= 4'h0;
                        end
                    end
                end
                SAR_BITS: begin
                    if (dec_pt) begin
                        if (bitn_r == nframe) begin
                            state_r    <= SAR_IDLE;  // next start may follow at once
                            prev_rxd_r <= 1'b1;
                        end else begin
                            bitn_r <= bitn_r + 4'h1;
                            if (bitn_r < ndata) begin
                                shift_r[bitn_r] <= bit_val;
                            end else begin
                                par_bit_r <= bit_val;
                            end
                        end
                    end
                end
                default: begin
                    state_r <= SAR_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // shifter hold, overrun and transfer into buffer
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            hold_r       <= 1'b0;
            hold_entry_r <= '0;
            dor_r        <= 1'b0;
        end else if (!en) begin
            hold_r <= 1'b0;
            dor_r  <= 1'b0;
        end else begin
            if (push) begin
                hold_r <= 1'b0;
                dor_r  <= 1'b0;
            end
            if (start_ok && hold_r && buf_full) begin
                dor_r <= 1'b1;
            end
            if (stop_pt && !(hold_r && !push)) begin
                hold_r <= 1'b1;
                hold_entry_r[DATA_W-1:0] <= shift_r[DATA_W-1:0] & dmask[DATA_W-1:0];
                hold_entry_r[POS_NINTH]  <= (ndata == 4'h9) & shift_r[8];
                hold_entry_r[POS_PERR]   <= perr;
                hold_entry_r[POS_FERR]   <= !bit_val;
            end
        end
    end

    // ------------------------------------------------------------------
    // registered outputs follow the buffer head, overrun state and enable
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_RX_DATA_REG        <= '0;
            O_RX_NINTH_BIT       <= 1'b0;
            O_FRAMING_ERROR_FLAG <= 1'b0;
            O_OVERRUN_FLAG       <= 1'b0;
            O_PARITY_ERROR_FLAG  <= 1'b0;
            O_RX_COMPLETE_FLAG   <= 1'b0;
            O_RX_COMPLETE_IRQ    <= 1'b0;
            O_PIN_OVERRIDE       <= 1'b0;
        end else begin
            O_RX_DATA_REG        <= head[DATA_W-1:0];
            O_RX_NINTH_BIT       <= head[POS_NINTH];
            O_FRAMING_ERROR_FLAG <= !buf_empty & head[POS_FERR];
            O_PARITY_ERROR_FLAG  <= !buf_empty & head[POS_PERR] & I_PARITY_ENABLE_BIT;
            O_OVERRUN_FLAG       <= dor_r;
            O_RX_COMPLETE_FLAG   <= !buf_empty;
            O_RX_COMPLETE_IRQ    <= !buf_empty & I_RX_COMPLETE_IRQ_ENABLE;
            O_PIN_OVERRIDE       <= en;
        end
    end
endmodule

// File: testbench/sar_receiver_props.sv
// checker for the serial receiver: port-level timing relations
// assumes it is bound to sar_receiver and sees only its ports
module sar_receiver_props
    import sar_pkg::*;
(
    // clock and reset
    input  wire logic       I_CLOCK,
    input  wire logic       I_RESETN,
    // configuration and read strobe
    input  wire logic       I_RECEIVER_ENABLE_BIT,
    input  wire logic       I_RX_COMPLETE_IRQ_ENABLE,
    input  wire logic       I_PARITY_ENABLE_BIT,
    input  wire logic [2:0] I_CHAR_SIZE_FIELD,
    input  wire logic       I_RX_DATA_READ,
    // status outputs
    input  wire logic [7:0] O_RX_DATA_REG,
    input  wire logic       O_RX_NINTH_BIT,
    input  wire logic       O_FRAMING_ERROR_FLAG,
    input  wire logic       O_OVERRUN_FLAG,
    input  wire logic       O_PARITY_ERROR_FLAG,
    input  wire logic       O_RX_COMPLETE_FLAG,
    input  wire logic       O_RX_COMPLETE_IRQ,
    input  wire logic       O_PIN_OVERRIDE
);
    // ------------------------------------------------------------------
    // one clock domain
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESETN);

    // interrupt follows flag while enabled, never without flag
    a_irq_while_flag: assert property (I_RX_COMPLETE_IRQ_ENABLE && O_RX_COMPLETE_FLAG
        && $past(I_RX_COMPLETE_IRQ_ENABLE) |-> O_RX_COMPLETE_IRQ) else $error("irq missing");
    a_irq_no_flag: assert property (!O_RX_COMPLETE_FLAG |-> !O_RX_COMPLETE_IRQ)
        else $error("irq without complete flag");
    // disable flushes the buffer and overrun state
    a_disable_flush: assert property (!I_RECEIVER_ENABLE_BIT [*2] |=>
        !O_RX_COMPLETE_FLAG && !O_OVERRUN_FLAG) else $error("buffer not flushed");
    // pin ownership follows enable one clock later
    a_pin_release: assert property ($fell(I_RECEIVER_ENABLE_BIT) |=> !O_PIN_OVERRIDE)
        else $error("pin not released");
    a_pin_take: assert property ($rose(I_RECEIVER_ENABLE_BIT) |=> O_PIN_OVERRIDE)
        else $error("pin not taken");
    // flag holds while nothing is read or flushed
    a_flag_hold: assert property (O_RX_COMPLETE_FLAG && !I_RX_DATA_READ && !$past(I_RX_DATA_READ)
        && I_RECEIVER_ENABLE_BIT |=> O_RX_COMPLETE_FLAG) else $error("flag dropped");
    // empty buffer shows no error status
    a_empty_clean: assert property (!O_RX_COMPLETE_FLAG |->
        !O_FRAMING_ERROR_FLAG && !O_PARITY_ERROR_FLAG) else $error("error flag while empty");
    // parity error reads zero with checking off
    a_parity_masked: assert property (!I_PARITY_ENABLE_BIT && !$past(I_PARITY_ENABLE_BIT)
        |-> !O_PARITY_ERROR_FLAG) else $error("parity error while disabled");
    // five-bit characters leave the upper bits zero
    a_upper_zero: assert property (O_RX_COMPLETE_FLAG && I_CHAR_SIZE_FIELD == SIZE_5BIT
        && $stable(I_CHAR_SIZE_FIELD) |-> O_RX_DATA_REG[7:5] == 3'h0) else $error("upper bits");
    // overrun only with buffered data
    a_overrun_full: assert property ($rose(O_OVERRUN_FLAG) |-> O_RX_COMPLETE_FLAG)
        else $error("overrun with empty buffer");
endmodule

// File: testbench/sar_tx_model.sv
// remote serial transmitter model driving the receive line
// assumes bit times are given in system clocks
module sar_tx_model (
    input  wire logic i_clock,
    output logic      o_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle line is high
    initial o_line = 1'b1;

    // hold one level for n clocks, changed just after an edge
    task automatic level(input logic v, input int n);
        @(posedge i_clock);
        #1 o_line = v;
        repeat (n - 1) @(posedge i_clock);
    endtask

    // one frame: start, data lsb first, optional parity, first stop, idle bit
    task automatic send(input logic [8:0] d, input int nb, input logic has_par,
                        input logic par, input logic stp, input int bclk);
        level(1'b0, bclk);
        for (int i = 0; i < nb; i++) begin
            level(d[i], bclk);
        end
        if (has_par) begin
            level(par, bclk);
        end
        level(stp, bclk);
        level(1'b1, bclk);
    endtask
endmodule

// File: testbench/sar_receiver_tb_top.sv
// self-checking bench for the serial receiver
// assumes a sample tick every 4 clocks, so a bit lasts 64 or 32 clocks
module sar_receiver_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sar_pkg::*;

    logic       clk, rst_n, en, irq_en, pen, podd, dbl, rd;
    logic [2:0] csz;
    logic [7:0] data;
    logic       rxd, ninth, fe, ovr, pe, rx_complete_flag, irq, ovrd;
    int         fail_count = 0;
    int         checks_done = 0;
    int         cyc = 0;

    sar_tx_model u_tx (.i_clock(clk), .o_line(rxd));
    sar_receiver u_dut (.I_CLOCK(clk), .I_RESETN(rst_n), .I_RXD(rxd),
        .I_RECEIVER_ENABLE_BIT(en), .I_RX_COMPLETE_IRQ_ENABLE(irq_en),
        .I_PARITY_ENABLE_BIT(pen), .I_PARITY_ODD_SELECT(podd), .I_STOP_BITS_SELECT(1'b1),
        .I_DOUBLE_SPEED_BIT(dbl), .I_CHAR_SIZE_FIELD(csz), .I_BAUD_DIV(12'h003),
        .I_RX_DATA_READ(rd), .O_RX_DATA_REG(data), .O_RX_NINTH_BIT(ninth),
        .O_FRAMING_ERROR_FLAG(fe), .O_OVERRUN_FLAG(ovr), .O_PARITY_ERROR_FLAG(pe),
        .O_RX_COMPLETE_FLAG(rx_complete_flag), .O_RX_COMPLETE_IRQ(irq), .O_PIN_OVERRIDE(ovrd));

    // ------------------------------------------------------------------
    // clock, timeout, reporting
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (fail_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------------
    // disable then enable with a new format, which also empties the buffer
    task automatic cfg(input logic p, input logic o, input logic d, input logic [2:0] s);
        @(posedge clk);
        #1 en = 1'b0;
        pen = p; podd = o; dbl = d; csz = s;
        repeat (3) @(posedge clk);
        #1 en = 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic tx(input logic [8:0] d, input int nb, input logic pb, input logic stp);
        u_tx.send(d, nb, pen, pb, stp, dbl ? 32 : 64);
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic pop();
        @(posedge clk);
        #1 rd = 1'b1;
        @(posedge clk);
        #1 rd = 1'b0;
        @(posedge clk);
        #1;
    endtask
    // status first, then the read that advances the buffer
    task automatic head(input logic [7:0] d, input logic n9, input logic f, input logic p);
        check("complete", rx_complete_flag, 1);
        check("data", data, d);
        check("ninth", ninth, n9);
        check("framing", fe, f);
        check("parity", pe, p);
        pop();
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_basic();
        cfg(0, 0, 0, 3'h3);
        irq_en = 1'b1;
        tx(9'h0a5, 8, 0, 1);
        check("irq", irq, 1);
        head(8'ha5, 0, 0, 0);
        check("complete", rx_complete_flag, 0);
        check("irq", irq, 0);
    endtask
    task automatic t_parity();
        for (int i = 0; i < 4; i++) begin
            cfg(1, i[0], 0, 3'h3);
            tx(9'h0c3, 8, (^8'hc3) ^ i[0] ^ i[1], 1);
            repeat (40) @(posedge clk);
            head(8'hc3, 0, 0, i[1]);
        end
        cfg(0, 0, 0, 3'h3);
        tx(9'h0c3, 8, 0, 1);
        head(8'hc3, 0, 0, 0);
    endtask
    task automatic t_framing();
        cfg(0, 0, 0, 3'h3);
        tx(9'h03c, 8, 0, 0);
        tx(9'h05a, 8, 0, 1);
        head(8'h3c, 0, 1, 0);
        head(8'h5a, 0, 0, 0);
    endtask
    task automatic t_overrun();
        cfg(0, 0, 0, 3'h3);
        tx(9'h011, 8, 0, 1);
        tx(9'h022, 8, 0, 1);
        tx(9'h033, 8, 0, 1);
        check("overrun", ovr, 0);
        tx(9'h044, 8, 0, 1);
        check("overrun", ovr, 1);
        head(8'h11, 0, 0, 0);
        repeat (4) @(posedge clk);
        check("overrun", ovr, 0);
        head(8'h22, 0, 0, 0);
        check("data", data, 8'h33);
        for (int i = 0; i < 4 && rx_complete_flag; i++) pop();
        check("complete", rx_complete_flag, 0);
    endtask
    task automatic t_noise();
        cfg(0, 0, 0, 3'h3);
        u_tx.level(1'b0, 20);
        u_tx.level(1'b1, 64);
        tx(9'h096, 8, 0, 1);
        head(8'h96, 0, 0, 0);
        check("complete", rx_complete_flag, 0);
    endtask
    task automatic t_formats();
        cfg(0, 0, 1, 3'h3);
        tx(9'h06e, 8, 0, 1);
        head(8'h6e, 0, 0, 0);
        cfg(0, 0, 0, SIZE_9BIT);
        tx(9'h1b4, 9, 0, 1);
        head(8'hb4, 1, 0, 0);
        cfg(0, 0, 0, SIZE_5BIT);
        tx(9'h0f5, 5, 0, 1);
        head(8'h15, 0, 0, 0);
    endtask
    task automatic t_disable();
        cfg(0, 0, 0, 3'h3);
        tx(9'h0e7, 8, 0, 1);
        fork
            u_tx.send(9'h081, 8, 0, 0, 1, 64);
            begin
                repeat (300) @(posedge clk);
                #1 en = 1'b0;
                repeat (3) @(posedge clk);
                check("complete", rx_complete_flag, 0);
                check("override", ovrd, 0);
            end
        join
        #1 en = 1'b1;
        repeat (20) @(posedge clk);
        check("complete", rx_complete_flag, 0);
        check("override", ovrd, 1);
        tx(9'h07e, 8, 0, 1);
        head(8'h7e, 0, 0, 0);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0; en = 1'b0; irq_en = 1'b0; pen = 1'b0; podd = 1'b0;
        dbl = 1'b0; rd = 1'b0; csz = 3'h3;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        check("complete", rx_complete_flag, 0);
        check("flags", {fe, ovr, pe, irq}, 0);
        t_basic();
        t_parity();
        t_framing();
        t_overrun();
        t_noise();
        t_formats();
        t_disable();
        finish_test();
    end
endmodule

bind sar_receiver sar_receiver_props u_props (.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN),
    .I_RECEIVER_ENABLE_BIT(I_RECEIVER_ENABLE_BIT),
    .I_RX_COMPLETE_IRQ_ENABLE(I_RX_COMPLETE_IRQ_ENABLE),
    .I_PARITY_ENABLE_BIT(I_PARITY_ENABLE_BIT), .I_CHAR_SIZE_FIELD(I_CHAR_SIZE_FIELD),
    .I_RX_DATA_READ(I_RX_DATA_READ), .O_RX_DATA_REG(O_RX_DATA_REG),
    .O_RX_NINTH_BIT(O_RX_NINTH_BIT), .O_FRAMING_ERROR_FLAG(O_FRAMING_ERROR_FLAG),
    .O_OVERRUN_FLAG(O_OVERRUN_FLAG), .O_PARITY_ERROR_FLAG(O_PARITY_ERROR_FLAG),
    .O_RX_COMPLETE_FLAG(O_RX_COMPLETE_FLAG), .O_RX_COMPLETE_IRQ(O_RX_COMPLETE_IRQ),
    .O_PIN_OVERRIDE(O_PIN_OVERRIDE));
